// ### src/pco_power_ctl.v
// Power control outputs for the I/O bus and video functions, APB slave.
`default_nettype none
`include "pco_map.vh"

module pco_power_ctl
#(
   parameter IO_OUT_W = 32,
   parameter CLR_HOLD_CYC = `PCO_CLR_HOLD_CYC,
   parameter [15:0] ID_VALUE = `PCO_ID_VALUE
)
(
   input wire clk_sys,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PCO_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [IO_OUT_W-1:0] ioBusOutRaw,
   input wire dacAnalogSupplyOk,
   output reg ioBusSupplyCtl,
   output reg ioDeviceClear,
   output reg ioDeviceClear_n,
   output reg [IO_OUT_W-1:0] ioBusOut,
   output reg [`PCO_VID_W-1:0] videoPowerCtl,
   output reg dacPowerBit
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   localparam HOLD_W = 16;
   localparam [31:0] HOLD_SPAN = CLR_HOLD_CYC - 1;
   localparam [HOLD_W-1:0] HOLD_LAST = HOLD_SPAN[HOLD_W-1:0];

   reg supplyEn_q;
   reg supplyEn_d;
   reg clearReq_q;
   reg clearReq_d;
   reg [`PCO_VID_W-1:0] video_q;
   reg [`PCO_VID_W-1:0] video_d;
   reg dacPwr_q;
   reg dacPwr_d;
   reg [HOLD_W-1:0] holdCnt_q;
   reg [HOLD_W-1:0] holdCnt_d;
   reg holdActive_q;
   reg holdActive_d;
   reg [31:0] readData;
   reg addrHit;
   wire accessPhase;
   wire writeNow;
   wire lane0;
   wire clearActive;
   wire [IO_OUT_W-1:0] busGated;

   ////////////////////////////////////////////////////////////////////////////
   // APB handshake: one wait state, answer in the second access cycle.

   // A write takes effect only at the edge where pready is sampled high.
   assign accessPhase = psel & penable;
   assign writeNow = accessPhase & pready & pwrite;
   assign lane0 = pstrb[0];

   // Address decode and read multiplexer.
   always @*
   begin
      addrHit = 1'b1;
      readData = 32'h0000_0000;
      case (paddr)
         `PCO_OFS_SUPPLY:
         begin
            readData[`PCO_SUPPLY_EN_BIT] = supplyEn_q;
         end
         `PCO_OFS_CLEAR:
         begin
            readData[`PCO_CLEAR_BIT] = clearReq_q;
         end
         `PCO_OFS_VIDEO:
         begin
            readData[`PCO_VID_W-1:0] = video_q;
         end
         `PCO_OFS_DAC:
         begin
            readData[`PCO_DAC_PWR_BIT] = dacPwr_q;
         end
         `PCO_OFS_STATUS:
         begin
            readData[`PCO_ST_SUPPLY_BIT] = ioBusSupplyCtl;
            readData[`PCO_ST_CLEAR_BIT] = ioDeviceClear;
            readData[`PCO_ST_VID_LSB+`PCO_VID_W-1:`PCO_ST_VID_LSB] =
               videoPowerCtl;
            readData[`PCO_ST_DACPWR_BIT] = dacPowerBit;
            readData[`PCO_ST_ANALOG_BIT] = dacAnalogSupplyOk;
            readData[`PCO_ST_HOLD_BIT] = holdActive_q;
         end
         `PCO_OFS_ID:
         begin
            readData[15:0] = ID_VALUE;
         end
         default:
         begin
            addrHit = 1'b0;
         end
      endcase
   end

   // Bus answer registers; unmapped addresses answer with an error.
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (accessPhase && !pready)
      begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : readData;
         pslverr <= ~addrHit;
      end
      else
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers written by software.

   // Next values of the control bits; byte lane 0 carries every field.
   always @*
   begin
      supplyEn_d = supplyEn_q;
      clearReq_d = clearReq_q;
      video_d = video_q;
      dacPwr_d = dacPwr_q;
      if (writeNow && lane0 && addrHit)
      begin
         case (paddr)
            `PCO_OFS_SUPPLY:
            begin
               supplyEn_d = pwdata[`PCO_SUPPLY_EN_BIT];
            end
            `PCO_OFS_CLEAR:
            begin
               clearReq_d = pwdata[`PCO_CLEAR_BIT];
            end
            `PCO_OFS_VIDEO:
            begin
               video_d = pwdata[`PCO_VID_W-1:0];
            end
            `PCO_OFS_DAC:
            begin
               dacPwr_d = pwdata[`PCO_DAC_PWR_BIT];
            end
            default:
            begin
               supplyEn_d = supplyEn_q;
            end
         endcase
      end
      // The DAC power bit cannot stand without the analog supply present.
      if (!dacAnalogSupplyOk)
      begin
         dacPwr_d = 1'b0;
      end
   end

   // Control bits start inactive after reset.
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         supplyEn_q <= `PCO_RST_SUPPLY;
         clearReq_q <= `PCO_RST_CLEAR;
         video_q <= `PCO_RST_VIDEO;
         dacPwr_q <= `PCO_RST_DAC;
      end
      else
      begin
         supplyEn_q <= supplyEn_d;
         clearReq_q <= clearReq_d;
         video_q <= video_d;
         dacPwr_q <= dacPwr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-up clear hold on the bus device.

   // Each switch-on of the bus supply holds the device clear for a fixed time.
   always @*
   begin
      holdCnt_d = holdCnt_q;
      holdActive_d = holdActive_q;
      if (!supplyEn_q)
      begin
         holdCnt_d = {HOLD_W{1'b0}};
         holdActive_d = 1'b0;
      end
      else if (supplyEn_d && !ioBusSupplyCtl && !holdActive_q)
      begin
         holdCnt_d = {HOLD_W{1'b0}};
         holdActive_d = 1'b1;
      end
      else if (holdActive_q)
      begin
         if (holdCnt_q == HOLD_LAST)
         begin
            holdActive_d = 1'b0;
         end
         else
         begin
            holdCnt_d = holdCnt_q + 16'h0001;
         end
      end
   end

   // Hold counter registers.
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         holdCnt_q <= {HOLD_W{1'b0}};
         holdActive_q <= 1'b0;
      end
      else
      begin
         holdCnt_q <= holdCnt_d;
         holdActive_q <= holdActive_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output flip-flops.

   // Clear is only driven while the bus is powered; otherwise all lines low.
   assign clearActive = supplyEn_q & (clearReq_q | holdActive_d);
   assign busGated = supplyEn_q ? ioBusOutRaw : {IO_OUT_W{1'b0}};

   // Every output is registered and low during reset.
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         ioBusSupplyCtl <= 1'b0;
         ioDeviceClear <= 1'b0;
         ioDeviceClear_n <= 1'b0;
         ioBusOut <= {IO_OUT_W{1'b0}};
         videoPowerCtl <= `PCO_RST_VIDEO;
         dacPowerBit <= 1'b0;
      end
      else
      begin
         ioBusSupplyCtl <= supplyEn_q;
         ioDeviceClear <= clearActive;
         ioDeviceClear_n <= supplyEn_q & ~clearActive;
         ioBusOut <= busGated;
         videoPowerCtl[`PCO_VID_VRAMOSC_BIT] <=
            video_q[`PCO_VID_VRAMOSC_BIT];
         videoPowerCtl[`PCO_VID_LCDOSC_BIT] <=
            video_q[`PCO_VID_LCDOSC_BIT];
         videoPowerCtl[`PCO_VID_RAMDAC_BIT] <=
            video_q[`PCO_VID_RAMDAC_BIT];
         dacPowerBit <= dacPwr_q & dacAnalogSupplyOk;
      end
   end

endmodule // pco_power_ctl
`default_nettype wire

// ### pkg/pco_map.vh
// Register map, field positions, reset values and timing of the power block.
// Function
// - Provide supply control, device clear pair, three-bit video power.
// - Supply control output switches the whole 5 V rail of the I/O bus.
// - With supply control deasserted, every I/O bus output is driven low.
// - Clear pair resets one bus device; others need separate host pins.
// - Video power bit 2 enables the video memory control oscillator.
// - Video power bit 1 enables the LCD module oscillator.
// - Video power bit 0 drives the switch gating the video DAC supply.
`ifndef PCO_MAP_VH
`define PCO_MAP_VH

// Register byte offsets on the APB slave.
`define PCO_ADDR_W 8
`define PCO_OFS_SUPPLY 8'h00
`define PCO_OFS_CLEAR 8'h04
`define PCO_OFS_VIDEO 8'h08
`define PCO_OFS_DAC 8'h0C
`define PCO_OFS_STATUS 8'h10
`define PCO_OFS_ID 8'h14

// Field positions.
`define PCO_SUPPLY_EN_BIT 0
`define PCO_CLEAR_BIT 0
`define PCO_VID_RAMDAC_BIT 0
`define PCO_VID_LCDOSC_BIT 1
`define PCO_VID_VRAMOSC_BIT 2
`define PCO_VID_W 3
`define PCO_DAC_PWR_BIT 1
`define PCO_ST_SUPPLY_BIT 0
`define PCO_ST_CLEAR_BIT 1
`define PCO_ST_VID_LSB 2
`define PCO_ST_DACPWR_BIT 5
`define PCO_ST_ANALOG_BIT 6
`define PCO_ST_HOLD_BIT 7

// Reset values: every control bit inactive.
`define PCO_RST_SUPPLY 1'h0
`define PCO_RST_CLEAR 1'h0
`define PCO_RST_VIDEO 3'h0
`define PCO_RST_DAC 1'h0

// Arbitrary neutral identity value.
`define PCO_ID_VALUE 16'h5A01

// Timing: clock period and power-up clear hold time.
`define PCO_CLK_NS 10
`define PCO_CLR_HOLD_NS 10000
`define PCO_CLR_HOLD_CYC ((`PCO_CLR_HOLD_NS + `PCO_CLK_NS - 1) / `PCO_CLK_NS)

`endif

// ### tb/pco_power_ctl_props.sv
// Port checker for the power control block, bound into its top module.
`default_nettype none
`include "pco_map.vh"

module pco_power_ctl_props
#(
   parameter IO_OUT_W = 32
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`PCO_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [IO_OUT_W-1:0] ioBusOutRaw,
   input wire logic dacAnalogSupplyOk,
   input wire logic ioBusSupplyCtl,
   input wire logic ioDeviceClear,
   input wire logic ioDeviceClear_n,
   input wire logic [IO_OUT_W-1:0] ioBusOut,
   input wire logic [`PCO_VID_W-1:0] videoPowerCtl,
   input wire logic dacPowerBit
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // A completed APB write to one address with byte lane 0 enabled.
   sequence s_wr(logic [7:0] a);
      psel && penable && pready && pwrite && pstrb[0] && paddr == a;
   endsequence

   ////////////////////////////////////////////////////////////////////////
   a_wait_state: assert property (psel && penable && !pready |=> pready)
      else $error("No ready after one wait state.");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("Ready stood longer than one cycle.");
   a_err_unmapped: assert property (pready && paddr > `PCO_OFS_ID |->
      pslverr)
      else $error("Unmapped access without error.");
   a_reset_idle: assert property ($rose(rst_n) |->
      !ioBusSupplyCtl && videoPowerCtl == 3'h0 && !dacPowerBit)
      else $error("Outputs not inactive after reset.");
   a_supply_write: assert property (s_wr(`PCO_OFS_SUPPLY) |->
      ##2 ioBusSupplyCtl == $past(pwdata[0], 2))
      else $error("Supply output does not follow its write.");
   a_video_write: assert property (s_wr(`PCO_OFS_VIDEO) |->
      ##2 videoPowerCtl == $past(pwdata[2:0], 2))
      else $error("Video power outputs do not follow their write.");
   a_bus_low: assert property (!ioBusSupplyCtl |-> ioBusOut == '0 &&
      !ioDeviceClear_n)
      else $error("Bus lines not low with supply off.");
   a_clear_pair: assert property (ioBusSupplyCtl |->
      ioDeviceClear_n != ioDeviceClear)
      else $error("Clear pair disagrees.");
   a_clear_hold: assert property ($rose(ioBusSupplyCtl) |->
      ioDeviceClear [*4])
      else $error("Power-up clear too short.");
   a_dac_guard: assert property (!dacAnalogSupplyOk |=> !dacPowerBit)
      else $error("DAC power bit set without analog supply.");
endmodule // pco_power_ctl_props

bind pco_power_ctl pco_power_ctl_props #(.IO_OUT_W(IO_OUT_W))
   pco_power_ctl_props_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ioBusOutRaw(ioBusOutRaw), .dacAnalogSupplyOk(dacAnalogSupplyOk),
   .ioBusSupplyCtl(ioBusSupplyCtl), .ioDeviceClear(ioDeviceClear),
   .ioDeviceClear_n(ioDeviceClear_n), .ioBusOut(ioBusOut),
   .videoPowerCtl(videoPowerCtl), .dacPowerBit(dacPowerBit));
`default_nettype wire

// ### tb/pco_board_model.sv
// Board model: analog DAC supply switch and the I/O bus controller drive.
`default_nettype none

module pco_board_model
#(
   parameter logic [31:0] PATTERN = 32'h0
)
(
   input wire logic clk_sys,
   input wire logic analogOn,
   output logic dacAnalogSupplyOk,
   output logic [31:0] ioBusOutRaw
);
   timeunit 1ns;
   timeprecision 1ns;

   // The analog supply settles one cycle after its switch moves.
   always_ff @(posedge clk_sys)
      dacAnalogSupplyOk <= analogOn;

   // The bus controller drives a fixed pattern on its raw lines.
   assign ioBusOutRaw = PATTERN;
endmodule // pco_board_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the power control block over APB.
`default_nettype none
`include "pco_map.vh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] TB_ID = 16'hC3A5; // Arbitrary identity value.
   localparam logic [31:0] RAW = 32'hA5C3_0F96;
   logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic analogOn = 0, pready, pslverr, dacAnalogSupplyOk, er;
   logic ioBusSupplyCtl, ioDeviceClear, ioDeviceClear_n, dacPowerBit;
   logic [7:0] paddr = 0;
   logic [3:0] pstrb = 0;
   logic [31:0] pwdata = 0, prdata, ioBusOutRaw, ioBusOut, rd;
   logic [2:0] videoPowerCtl;
   int errors = 0, n_compared = 0;

   pco_power_ctl #(.IO_OUT_W(32), .CLR_HOLD_CYC(4), .ID_VALUE(TB_ID))
      pco_power_ctl_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ioBusOutRaw(ioBusOutRaw), .dacAnalogSupplyOk(dacAnalogSupplyOk),
      .ioBusSupplyCtl(ioBusSupplyCtl), .ioDeviceClear(ioDeviceClear),
      .ioDeviceClear_n(ioDeviceClear_n), .ioBusOut(ioBusOut),
      .videoPowerCtl(videoPowerCtl), .dacPowerBit(dacPowerBit));
   pco_board_model #(.PATTERN(RAW)) pco_board_model_i (.clk_sys(clk_sys),
      .analogOn(analogOn), .dacAnalogSupplyOk(dacAnalogSupplyOk),
      .ioBusOutRaw(ioBusOutRaw));

   ////////////////////////////////////////////////////////////////////////
   // Clock at 100 MHz.
   always #5 clk_sys = ~clk_sys;

   // Compares a value seen with the one expected.
   task automatic chk(input logic [32:0] s, input logic [32:0] e);
      n_compared++;
      if (s !== e)
      begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // One APB transfer; read data and error land in rd and er.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Prints the verdict and ends the run.
   task automatic close_out();
      if (errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog against a hung handshake.
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence of tests.
   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int a = 0; a <= 16; a += 4)
      begin
         apb(1'b0, 8'(a), 32'h0, 4'hF);
         chk(rd, 33'h0);
      end
      apb(1'b0, `PCO_OFS_ID, 32'h0, 4'hF);
      chk(rd, {17'h0, TB_ID});
      apb(1'b0, 8'h18, 32'h0, 4'hF);
      chk({er, rd}, {1'b1, 32'h0});
      chk({ioBusOut, ioDeviceClear_n}, 33'h0);
      for (int v = 0; v < 8; v++)
      begin
         apb(1'b1, `PCO_OFS_VIDEO, 32'(v), 4'hF);
         apb(1'b0, `PCO_OFS_VIDEO, 32'h0, 4'hF);
         chk({rd, 1'b0}, {32'(v), 1'b0});
         chk(videoPowerCtl, 33'(v));
      end
      apb(1'b1, `PCO_OFS_SUPPLY, 32'h1, 4'h0);
      apb(1'b1, `PCO_OFS_STATUS, 32'hFF, 4'hF);
      chk(ioBusSupplyCtl, 33'h0);
      apb(1'b1, `PCO_OFS_SUPPLY, 32'h1, 4'hF);
      repeat (2) @(posedge clk_sys);
      #1 chk({ioBusSupplyCtl, ioDeviceClear, ioDeviceClear_n}, 33'h6);
      repeat (8) @(posedge clk_sys);
      #1 chk({ioBusSupplyCtl, ioDeviceClear, ioDeviceClear_n}, 33'h5);
      chk(ioBusOut, {1'b0, RAW});
      apb(1'b1, `PCO_OFS_CLEAR, 32'h1, 4'hF);
      repeat (2) @(posedge clk_sys);
      #1 chk({ioDeviceClear, ioDeviceClear_n}, 33'h2);
      apb(1'b1, `PCO_OFS_CLEAR, 32'h0, 4'hF);
      apb(1'b1, `PCO_OFS_DAC, 32'h2, 4'hF);
      apb(1'b0, `PCO_OFS_DAC, 32'h0, 4'hF);
      chk(rd, 33'h0);
      analogOn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      apb(1'b1, `PCO_OFS_DAC, 32'h2, 4'hF);
      apb(1'b0, `PCO_OFS_DAC, 32'h0, 4'hF);
      chk({rd, dacPowerBit}, 33'h5);
      apb(1'b0, `PCO_OFS_STATUS, 32'h0, 4'hF);
      chk(rd, 33'h7D);
      apb(1'b1, `PCO_OFS_DAC, 32'h0, 4'hF);
      analogOn <= 1'b0;
      apb(1'b1, `PCO_OFS_SUPPLY, 32'h0, 4'hF);
      repeat (2) @(posedge clk_sys);
      #1 chk({ioBusOut, ioDeviceClear_n}, 33'h0);
      close_out();
   end
endmodule // tb_top
`default_nettype wire
